// >>> hdl/holdoff_timer.sv
// busy window that follows a soft reset
// assumes a one-cycle start pulse synchronous to clk
`timescale 1ns/1ps
module holdoff_timer #(
    parameter int CYCLES = 220000
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    output logic busy
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;
    logic busy_r;
    logic busy_nxt;

    // reload on start, otherwise count down to zero
    always_comb begin
        count_nxt = count_r;
        if (start) begin
            count_nxt = W'(CYCLES);
        end else if (count_r != '0) begin
            count_nxt = count_r - 1'b1;
        end
        busy_nxt = (count_nxt != '0);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_r <= '0;
            busy_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign busy = busy_r;
endmodule : holdoff_timer

// >>> hdl/sensor_status_and_conversion.sv
// status and configuration register of the sensor, with measurement setup
// assumes a serial front end that decodes commands into one-cycle pulses
// Functional notes
// - a status read returns one byte; a status write takes one byte
// - bit 0 picks 12/14-bit (0) or 8/12-bit (1) humidity/temperature
// - bit 1 set skips calibration reload before each measurement
// - bit 2 turns the heater on until it is cleared
// - bit 6 flags low supply, updated only when a measurement completes
// - soft reset restores writable bits; commands wait 11 ms afterward
// - connection reset clears the interface only, register kept
`timescale 1ns/1ps
`include "sensor_status_defs.svh"
module sensor_status_and_conversion #(
    parameter int SOFT_RESET_CYCLES = `SOFT_RESET_WAIT_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cmd_status_write,
    input wire sensor_status_pkg::status_byte_t write_data,
    input wire logic cmd_status_read,
    output sensor_status_pkg::status_byte_t read_data,
    output logic read_valid,
    input wire logic cmd_soft_reset,
    input wire logic link_reset,
    input wire logic meas_start,
    input wire logic meas_done,
    input wire logic supply_low,
    output sensor_status_pkg::status_byte_t status_value,
    output logic heater_on,
    output logic meas_low_res,
    output logic reload_req,
    output logic meas_active,
    output logic cmd_busy
);
    import sensor_status_pkg::*;

    status_byte_t status_r;
    status_byte_t status_nxt;
    status_byte_t read_data_r;
    status_byte_t read_data_nxt;
    logic read_valid_r;
    logic read_valid_nxt;
    logic heater_r;
    logic heater_nxt;
    logic low_res_r;
    logic low_res_nxt;
    logic reload_r;
    logic reload_nxt;
    logic active_r;
    logic active_nxt;
    meas_state_t state_r;
    meas_state_t state_nxt;
    logic busy;
    logic wr_ok;
    logic rd_ok;
    logic start_ok;

    // keeps only the writable configuration bits of a byte
    function automatic status_byte_t writable(input status_byte_t b);
        writable = b & `STAT_WRITE_MASK;
    endfunction : writable

    // status writes, reads and measurement starts are ignored while the soft-reset wait runs; a new soft reset restarts it
    holdoff_timer #(
        .CYCLES(SOFT_RESET_CYCLES)
    ) u_holdoff (
        .clk(clk),
        .rst_b(rst_b),
        .start(cmd_soft_reset),
        .busy(busy)
    );

    assign wr_ok = cmd_status_write && !busy && !cmd_soft_reset;
    assign rd_ok = cmd_status_read && !busy && !cmd_soft_reset && !link_reset;
    assign start_ok = meas_start && !busy && !cmd_soft_reset;

    // register contents: writes, soft reset and low-supply refresh
    always_comb begin
        status_nxt = status_r;
        if (cmd_soft_reset) begin
            status_nxt = writable(`STAT_RESET) | (status_r & ~`STAT_WRITE_MASK);
        end else if (wr_ok) begin
            status_nxt = writable(write_data) | (status_r & ~`STAT_WRITE_MASK);
        end
        // link_reset deliberately leaves the register alone
        if (state_r == MEAS_CONVERT && meas_done) begin
            status_nxt[`STAT_BIT_LOW_SUPPLY] = supply_low;
        end
        heater_nxt = status_nxt[`STAT_BIT_HEATER];
    end

    // single byte read answer
    always_comb begin
        read_data_nxt = read_data_r;
        read_valid_nxt = 1'b0;
        if (rd_ok) begin
            read_data_nxt = status_r;
            read_valid_nxt = 1'b1;
        end
    end

    // measurement sequencing, settings frozen at start
    always_comb begin
        state_nxt = state_r;
        low_res_nxt = low_res_r;
        reload_nxt = 1'b0;
        case (state_r)
            MEAS_IDLE: begin
                if (start_ok) begin
                    low_res_nxt = status_r[`STAT_BIT_LOW_RES];
                    if (!status_r[`STAT_BIT_NO_RELOAD]) begin
                        state_nxt = MEAS_RELOAD;
                        reload_nxt = 1'b1;
                    end else begin
                        state_nxt = MEAS_CONVERT;
                    end
                end
            end
            MEAS_RELOAD: begin
                state_nxt = MEAS_CONVERT;
            end
            MEAS_CONVERT: begin
                if (meas_done) begin
                    state_nxt = MEAS_IDLE;
                end
            end
            default: begin
                state_nxt = MEAS_IDLE;
            end
        endcase
        if (cmd_soft_reset) begin
            state_nxt = MEAS_IDLE;
            reload_nxt = 1'b0;
        end
        active_nxt = (state_nxt != MEAS_IDLE);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_r <= `STAT_RESET;
            read_data_r <= 8'h00;
            read_valid_r <= 1'b0;
            heater_r <= 1'b0;
            low_res_r <= 1'b0;
            reload_r <= 1'b0;
            active_r <= 1'b0;
            state_r <= MEAS_IDLE;
        end else begin
            status_r <= status_nxt;
            read_data_r <= read_data_nxt;
            read_valid_r <= read_valid_nxt;
            heater_r <= heater_nxt;
            low_res_r <= low_res_nxt;
            reload_r <= reload_nxt;
            active_r <= active_nxt;
            state_r <= state_nxt;
        end
    end

    // outputs straight from flops
    assign status_value = status_r;
    assign read_data = read_data_r;
    assign read_valid = read_valid_r;
    assign heater_on = heater_r;
    assign meas_low_res = low_res_r;
    assign reload_req = reload_r;
    assign meas_active = active_r;
    assign cmd_busy = busy;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_WRITE_STORES: assert property (wr_ok |=>
        status_value[2:0] == $past(write_data[2:0]))
        else $error("status write not stored");
    AST_READ_BYTE: assert property (rd_ok |=> read_valid &&
        read_data == $past(status_value))
        else $error("status read answer wrong");
    AST_READ_PULSE: assert property (!rd_ok |=> !read_valid)
        else $error("read answer without an accepted read");
    AST_HEATER_WRITE: assert property (wr_ok |=>
        heater_on == $past(write_data[`STAT_BIT_HEATER]))
        else $error("heater does not follow the written byte");
    AST_RES_LATCH: assert property (state_r == MEAS_IDLE && start_ok |=>
        meas_low_res == $past(status_value[`STAT_BIT_LOW_RES]) && meas_active)
        else $error("resolution not latched at start");
    AST_RES_HOLD: assert property ($past(meas_active) && meas_active |->
        $stable(meas_low_res))
        else $error("resolution changed mid measurement");
    AST_RELOAD_ON: assert property (state_r == MEAS_IDLE && start_ok &&
        !status_value[`STAT_BIT_NO_RELOAD] |=> reload_req ##1 !reload_req)
        else $error("reload pulse missing");
    AST_RELOAD_OFF: assert property (state_r == MEAS_IDLE && start_ok &&
        status_value[`STAT_BIT_NO_RELOAD] |=> !reload_req)
        else $error("reload issued although disabled");
    AST_HEATER: assert property (heater_on == status_value[`STAT_BIT_HEATER])
        else $error("heater does not follow bit 2");
    AST_LOW_SET: assert property (state_r == MEAS_CONVERT && meas_done |=>
        status_value[`STAT_BIT_LOW_SUPPLY] == $past(supply_low))
        else $error("low supply flag not refreshed");
    AST_LOW_HOLD: assert property (!(state_r == MEAS_CONVERT && meas_done) |=>
        $stable(status_value[`STAT_BIT_LOW_SUPPLY]))
        else $error("low supply flag moved without measurement");
    AST_RESERVED: assert property (status_value[7] == 1'b0 &&
        status_value[5:3] == 3'b000)
        else $error("reserved bits not zero");
    AST_SOFT_RESET: assert property (cmd_soft_reset |=>
        status_value[2:0] == 3'b000 && cmd_busy && !meas_active)
        else $error("soft reset incomplete");
    AST_LINK_RESET: assert property (link_reset && !cmd_soft_reset && !wr_ok |=>
        $stable(status_value[2:0]))
        else $error("connection reset touched register");

    COV_WRITE: cover property (wr_ok ##1 rd_ok ##1 read_valid);
    COV_MEAS_RELOAD: cover property (reload_req ##[1:20] meas_done);
    COV_WRITE_IN_MEAS: cover property (meas_active && wr_ok ##[1:20] !meas_active);
    COV_SOFT_RESET: cover property (cmd_soft_reset ##1 cmd_busy);
endmodule : sensor_status_and_conversion

// >>> inc/sensor_status_defs.svh
// register layout, reset values and timing counts of the status block
// assumes a 20 MHz core clock; included by bare name
`ifndef SENSOR_STATUS_DEFS_SVH
`define SENSOR_STATUS_DEFS_SVH

`define STAT_BIT_LOW_RES 0
`define STAT_BIT_NO_RELOAD 1
`define STAT_BIT_HEATER 2
`define STAT_BIT_TEST 3
`define STAT_BIT_LOW_SUPPLY 6
`define STAT_RESET 8'h00
`define STAT_WRITE_MASK 8'h07
`define STAT_LOW_SUPPLY_RESET 1'b0
`define CLK_FREQ_MHZ 20
`define SOFT_RESET_WAIT_US 11000
`define SOFT_RESET_WAIT_CYC (`SOFT_RESET_WAIT_US * `CLK_FREQ_MHZ)

`endif

// >>> inc/sensor_status_pkg.sv
// types shared by the status block
// assumes nothing beyond the defs header for numbers
package sensor_status_pkg;
    typedef logic [7:0] status_byte_t;
    // gray codes along idle -> reload -> convert
    typedef enum logic [1:0] {
        MEAS_IDLE = 2'b00,
        MEAS_RELOAD = 2'b01,
        MEAS_CONVERT = 2'b11
    } meas_state_t;
endpackage : sensor_status_pkg

// >>> verification/host_model.sv
// host side model: pulses the status block's decoded serial commands
// assumes each command is raised 2 ns after a rising edge of clk for one cycle
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    output logic cmd_status_write,
    output logic [7:0] write_data,
    output logic cmd_status_read,
    output logic cmd_soft_reset,
    output logic link_reset,
    output logic meas_start,
    output logic meas_done,
    output logic supply_low
);
    logic [7:0] last_cmd;

    // all commands idle from time zero
    initial begin
        {cmd_status_write, cmd_status_read, cmd_soft_reset} = 3'h0;
        {link_reset, meas_start, meas_done, supply_low} = 4'h0;
        write_data = 8'h00;
        last_cmd = 8'h00;
    end

    // command byte on the wire: address bits 000, then the five command bits
    function automatic logic [7:0] cmd_code(input int k);
        case (k)
            0: cmd_code = {3'h0, 5'h06};
            1: cmd_code = {3'h0, 5'h07};
            2: cmd_code = {3'h0, 5'h1e};
            4: cmd_code = {3'h0, 5'h05};
            default: cmd_code = 8'h00;
        endcase
    endfunction : cmd_code

    // linearised humidity from a raw count, saturated air reported as 100
    function automatic real rh_linear(input int humidity_raw_count, input logic low_res);
        real c2;
        real c3;
        real x;
        real r;
        c2 = low_res ? 0.5872 : 0.0367;
        c3 = low_res ? -4.0845e-4 : -1.5955e-6;
        x = humidity_raw_count;
        r = -2.0468 + c2 * x + c3 * x * x;
        if (r > 99.0) begin
            r = 100.0;
        end
        rh_linear = r;
    endfunction : rh_linear

    // humidity corrected for a temperature away from 25 degrees
    function automatic real rh_true(input real rh, input real t, input int humidity_raw_count,
        input logic low_res);
        real t2;
        t2 = low_res ? 0.00128 : 0.00008;
        rh_true = (t - 25.0) * (0.01 + t2 * humidity_raw_count) + rh;
    endfunction : rh_true

    // temperature from a raw count; d1 depends on the supply
    function automatic real temp_c(input int count, input logic low_res, input real d1);
        real d2;
        d2 = low_res ? 0.04 : 0.01;
        temp_c = d1 + d2 * count;
    endfunction : temp_c

    // dew point, water constants at or above zero, ice constants below
    function automatic real dew_point(input real rh, input real t);
        real tn;
        real m;
        real g;
        tn = (t < 0.0) ? 272.62 : 243.12;
        m = (t < 0.0) ? 22.46 : 17.62;
        g = $ln(rh / 100.0) + m * t / (tn + t);
        dew_point = tn * g / (m - g);
    endfunction : dew_point

    // one command pulse; k picks the command, d carries the byte or supply level
    task automatic cmd(input int k, input logic [7:0] d);
        @(posedge clk);
        #2;
        write_data = (k == 0) ? (d & 8'h07) : d;
        if (k < 3 || k == 4) begin
            last_cmd = cmd_code(k);
        end
        case (k)
            0: cmd_status_write = 1'b1;
            1: cmd_status_read = 1'b1;
            2: cmd_soft_reset = 1'b1;
            3: link_reset = 1'b1;
            4: meas_start = 1'b1;
            default: begin
                meas_done = 1'b1;
                supply_low = d[0];
            end
        endcase
        @(posedge clk);
        #2;
        {cmd_status_write, cmd_status_read, cmd_soft_reset} = 3'h0;
        {link_reset, meas_start, meas_done} = 3'h0;
        write_data = ~d; // released byte must not look valid
    endtask : cmd
endmodule : host_model

// >>> verification/test_sensor_status_and_conversion.sv
// self-checking bench of the status block with a host command model
// assumes a 20 MHz clock and a shortened soft-reset wait of 20 cycles
`timescale 1ns/1ps
module test_sensor_status_and_conversion;
    import sensor_status_pkg::*;
    logic clk, rst_b, wr, rd, srst, lrst, mst, mdn, slow;
    logic [7:0] wd, rdata, stat;
    logic rv, heat, lres, rreq, mact, busy;
    int err_count, tests_run;
    int n;
    logic [7:0] row_in [5] = '{8'h01, 8'h02, 8'h04, 8'h07, 8'hf8};
    logic [7:0] row_exp [5] = '{8'h01, 8'h02, 8'h04, 8'h07, 8'h00};

    sensor_status_and_conversion #(.SOFT_RESET_CYCLES(20)) u_dut (.clk(clk), .rst_b(rst_b),
        .cmd_status_write(wr), .write_data(wd), .cmd_status_read(rd), .read_data(rdata),
        .read_valid(rv), .cmd_soft_reset(srst), .link_reset(lrst), .meas_start(mst),
        .meas_done(mdn), .supply_low(slow), .status_value(stat), .heater_on(heat),
        .meas_low_res(lres), .reload_req(rreq), .meas_active(mact), .cmd_busy(busy));
    host_model u_host (.clk(clk), .cmd_status_write(wr), .write_data(wd),
        .cmd_status_read(rd), .cmd_soft_reset(srst), .link_reset(lrst), .meas_start(mst),
        .meas_done(mdn), .supply_low(slow));

    // compare one value against its expectation
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // whole part of a converted value, as a byte
    function automatic logic [7:0] whole(input real r);
        int v;
        v = $rtoi(r);
        whole = v[7:0];
    endfunction : whole

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // clock of 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // watchdog well beyond the expected run
    initial begin
        #200000;
        err_count++;
        close_out();
    end

    // main sequence
    initial begin
        err_count = 0;
        tests_run = 0;
        rst_b = 1'b0;
        repeat (4) @(posedge clk);
        #2 rst_b = 1'b1;
        chk({stat[7:0]}, 8'h00);
        chk({2'h0, heat, lres, rreq, mact, busy, rv}, 8'h00);
        chk(rdata, 8'h00);
        // table of writes, each read back
        for (int i = 0; i < 5; i++) begin
            u_host.cmd(0, row_in[i]);
            chk(stat, row_exp[i]);
            chk({7'h0, heat}, {7'h0, row_exp[i][2]});
            u_host.cmd(1, 8'h00);
            chk({7'h0, rv}, 8'h01);
            chk(rdata, row_exp[i]);
        end
        // low resolution with reload; done reports low supply
        u_host.cmd(0, 8'h05);
        u_host.cmd(4, 8'h00);
        chk({5'h0, mact, lres, rreq}, 8'h07);
        u_host.cmd(0, 8'h02); // new setting must wait for the next measurement
        chk({6'h0, lres, heat}, 8'h02);
        u_host.cmd(5, 8'h01);
        chk({7'h0, mact}, 8'h00);
        chk(stat, 8'h42);
        // no reload: no request, full resolution
        u_host.cmd(4, 8'h00);
        chk({5'h0, mact, lres, rreq}, 8'h04);
        u_host.cmd(5, 8'h00);
        chk(stat, 8'h02);
        // connection reset keeps the register
        u_host.cmd(0, 8'h07);
        u_host.cmd(3, 8'h00);
        chk(stat, 8'h07);
        // soft reset clears writable bits, refuses commands while busy
        u_host.cmd(2, 8'h00);
        chk(stat, 8'h00);
        chk({7'h0, busy}, 8'h01);
        chk(u_host.last_cmd, 8'h1e);
        u_host.cmd(0, 8'h05);
        chk(stat, 8'h00);
        // busy ends 20 edges after the soft reset; two have passed already
        n = 0;
        while (busy === 1'b1 && n < 40) begin
            @(posedge clk);
            #2;
            n++;
        end
        chk(n[7:0], 8'h12);
        chk({7'h0, busy}, 8'h00);
        u_host.cmd(0, 8'h03);
        chk(stat, 8'h03);
        chk(u_host.last_cmd, 8'h06);
        // host arithmetic against hand-worked values
        chk(whole(u_host.rh_linear(1073, 1'b0)), 8'h23);
        chk(whole(u_host.rh_linear(100, 1'b1)), 8'h34);
        chk(whole(u_host.rh_linear(4000, 1'b0)), 8'h64);
        chk(whole(u_host.rh_true(50.0, 75.0, 1000, 1'b0)), 8'h36);
        chk(whole(u_host.rh_true(50.0, 45.0, 100, 1'b1)), 8'h34);
        chk(whole(u_host.temp_c(6500, 1'b0, -40.1)), 8'h18);
        chk(whole(u_host.temp_c(1650, 1'b1, -40.1)), 8'h19);
        chk(whole(u_host.dew_point(50.0, 25.0)), 8'h0d);
        chk(whole(u_host.dew_point(80.0, -10.0)), 8'hf4);
        // reset in mid-run returns every setting to its default
        @(posedge clk);
        #2 rst_b = 1'b0;
        #1 chk(stat, 8'h00);
        repeat (4) @(posedge clk);
        #2 rst_b = 1'b1;
        u_host.cmd(0, 8'h04);
        chk({7'h0, heat}, 8'h01);
        close_out();
    end
endmodule : test_sensor_status_and_conversion
